// ==== design/lds_display_ram.sv ====
// Display memory, host access path and scan timing generator
// Functional notes
// - Byte bits stack down one column in page
// - Host access isolated from display readout
// - Page changes only by page command
// - Page 8 icon stores bit zero only
// - Column set by command, increments per access
// - Column increment halts at column 83h
// - Segment direction bit reverses column order
// - Start line picks topmost shown line
// - Display spans 65 memory lines
// - Start line change applies next frame
// - Icon line fixed per duty, ignores start
// - Latch applies inverse, on, all-on only
// - Oscillator runs only with both selects high
// - Clock source low takes external clock pin
// - Latch rows on display clock to segments
// - Frame signal gives two-frame alternating drive
// - Select high means data, low command
`timescale 1ns/1ps
`include "lds_defines.svh"
module lds_display_ram (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic host_wr_stb,
  input wire logic host_rd_stb,
  input wire logic data_command_select,
  input wire lds_pkg::lds_byte_t host_wdata,
  output lds_pkg::lds_byte_t host_rdata,
  output logic [3:0] current_page,
  output logic [7:0] current_column,
  input wire logic seg_reverse,
  input wire logic display_inverse,
  input wire logic display_on,
  input wire logic all_points_on,
  input wire lds_pkg::lds_duty_t duty_sel,
  input wire logic master_slave_select,
  input wire logic clock_source_select,
  input wire logic display_clock_pin,
  output logic osc_running,
  output logic [131:0] segment_output,
  output logic [6:0] common_index,
  output logic line_latch_stb,
  output logic frame_polarity_signal
);
  logic [64:0] mem_ff [0:131];
  logic [3:0] page_ff;
  logic [7:0] col_ff;
  lds_pkg::lds_byte_t holder_ff;
  lds_pkg::lds_byte_t rdata_ff;
  logic [5:0] start_ff;
  logic [5:0] start_act_ff;
  logic [2:0] pin_s1_ff;
  logic [2:0] pin_s2_ff;
  logic [2:0] pin_s3_ff;
  logic [2:0] pin_lvl_ff;
  logic [7:0] osc_cnt_ff;
  logic osc_run_ff;
  logic [6:0] scan_idx_ff;
  logic [131:0] seg_ff;
  logic [6:0] com_ff;
  logic latch_stb_ff;
  logic frame_ff;
  logic data_wr;
  logic data_rd;
  logic cmd_wr;
  logic col_ok;
  logic col_adv;
  logic osc_on;
  logic osc_tick;
  logic ext_rise;
  logic disp_tick;
  logic [6:0] icon_pos;
  logic frame_end;
  logic [6:0] line_sel;
  logic [131:0] row_bits;
  logic [131:0] nxt_seg;
  lds_pkg::lds_byte_t mem_byte;

  // Host transfer decode
  assign data_wr = host_wr_stb & data_command_select;
  assign cmd_wr = host_wr_stb & ~data_command_select;
  assign data_rd = host_rd_stb & data_command_select;
  assign col_ok = (col_ff <= `LDS_LAST_COL);
  assign col_adv = (data_wr | data_rd) & (col_ff < `LDS_LAST_COL);

  always_comb begin
    mem_byte = 8'h00;
    if (col_ok) begin
      if (page_ff == `LDS_ICON_PAGE) begin
        mem_byte = {7'h00, mem_ff[col_ff][`LDS_ICON_BIT]};
      end else if (!page_ff[3]) begin
        mem_byte = mem_ff[col_ff][{page_ff[2:0], 3'h0} +: 8];
      end
    end
  end

  // Page register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      page_ff <= `LDS_RST_PAGE;
    end else if (cmd_wr && host_wdata[7:4] == `LDS_CMD_PAGE) begin
      page_ff <= host_wdata[3:0];
    end
  end

  // Column counter
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      col_ff <= `LDS_RST_COL;
    end else if (cmd_wr && host_wdata[7:4] == `LDS_CMD_COL_LO) begin
      col_ff <= {col_ff[7:4], host_wdata[3:0]};
    end else if (cmd_wr && host_wdata[7:4] == `LDS_CMD_COL_HI) begin
      col_ff <= {host_wdata[3:0], col_ff[3:0]};
    end else if (col_adv) begin
      col_ff <= col_ff + 8'h01;
    end
  end

  // Start line, applied at frame boundary
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      start_ff <= `LDS_RST_START;
      start_act_ff <= `LDS_RST_START;
    end else begin
      if (cmd_wr && host_wdata[7:6] == `LDS_CMD_START) begin
        start_ff <= host_wdata[5:0];
      end
      if (frame_end) begin
        start_act_ff <= start_ff;
      end
    end
  end

  // Display memory write port
  always_ff @(posedge sys_clk) begin
    if (data_wr && col_ok) begin
      if (page_ff == `LDS_ICON_PAGE) begin
        mem_ff[col_ff][`LDS_ICON_BIT] <= host_wdata[0];
      end else if (!page_ff[3]) begin
        mem_ff[col_ff][{page_ff[2:0], 3'h0} +: 8] <= host_wdata;
      end
    end
  end

  // Bus holder read pipeline, first read after address set is stale
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      holder_ff <= 8'h00;
      rdata_ff <= 8'h00;
    end else if (data_rd) begin
      rdata_ff <= holder_ff;
      holder_ff <= mem_byte;
    end
  end

  // Pin synchronisers: ext clock, clock source, master select
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_s1_ff <= 3'h0;
      pin_s2_ff <= 3'h0;
      pin_s3_ff <= 3'h0;
      pin_lvl_ff <= 3'h0;
    end else begin
      pin_s1_ff <= {master_slave_select, clock_source_select,
                    display_clock_pin};
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      pin_lvl_ff <= (pin_s2_ff & ~(pin_s2_ff ^ pin_s3_ff)) |
                    (pin_lvl_ff & (pin_s2_ff ^ pin_s3_ff));
    end
  end

  assign osc_on = pin_lvl_ff[2] & pin_lvl_ff[1];
  assign osc_tick = osc_run_ff & (osc_cnt_ff == `LDS_OSC_DIV);
  assign ext_rise = (pin_s2_ff[0] == pin_s3_ff[0]) & pin_s2_ff[0] &
                    ~pin_lvl_ff[0];
  assign disp_tick = osc_on ? osc_tick : ext_rise;

  // Internal oscillator divider
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      osc_cnt_ff <= 8'h00;
      osc_run_ff <= 1'b0;
    end else begin
      osc_run_ff <= osc_on;
      if (!osc_on || osc_tick) begin
        osc_cnt_ff <= 8'h00;
      end else begin
        osc_cnt_ff <= osc_cnt_ff + 8'h01;
      end
    end
  end

  // Scan line selection
  always_comb begin
    unique case (duty_sel)
      lds_pkg::LDS_DUTY_49: icon_pos = `LDS_ICON_POS_49;
      lds_pkg::LDS_DUTY_33: icon_pos = `LDS_ICON_POS_33;
      default: icon_pos = `LDS_ICON_POS_65;
    endcase
  end

  assign frame_end = disp_tick & (scan_idx_ff >= icon_pos);
  assign line_sel = (scan_idx_ff >= icon_pos) ? `LDS_ICON_LINE :
                    {1'b0, start_act_ff + scan_idx_ff[5:0]};

  genvar s;
  generate
    for (s = 0; s < `LDS_COLS; s++) begin : g_seg
      localparam int RS = `LDS_COLS - 1 - s;
      assign row_bits[s] = seg_reverse ? mem_ff[RS][line_sel] :
                           mem_ff[s][line_sel];
    end
  endgenerate

  always_comb begin
    if (!display_on) begin
      nxt_seg = '0;
    end else if (all_points_on) begin
      nxt_seg = '1;
    end else begin
      nxt_seg = row_bits ^ {`LDS_COLS{display_inverse}};
    end
  end

  // Display latch and common timing
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      seg_ff <= '0;
      com_ff <= 7'h00;
      latch_stb_ff <= 1'b0;
      scan_idx_ff <= 7'h00;
    end else begin
      latch_stb_ff <= disp_tick;
      if (disp_tick) begin
        seg_ff <= nxt_seg;
        com_ff <= scan_idx_ff;
        scan_idx_ff <= frame_end ? 7'h00 : scan_idx_ff + 7'h01;
      end
    end
  end

  // Frame alternation
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      frame_ff <= 1'b0;
    end else if (frame_end) begin
      frame_ff <= ~frame_ff;
    end
  end

  assign host_rdata = rdata_ff;
  assign current_page = page_ff;
  assign current_column = col_ff;
  assign osc_running = osc_run_ff;
  assign segment_output = seg_ff;
  assign common_index = com_ff;
  assign line_latch_stb = latch_stb_ff;
  assign frame_polarity_signal = frame_ff;

  a_col_step: assert property (@(posedge sys_clk) disable iff (rst)
    (data_wr && col_ff < `LDS_LAST_COL) |=> col_ff == $past(col_ff) + 8'h01)
    else $error("column did not step");
  a_col_stop: assert property (@(posedge sys_clk) disable iff (rst)
    (data_rd && col_ff == `LDS_LAST_COL && !cmd_wr) |=> col_ff == `LDS_LAST_COL)
    else $error("column passed last");
  a_page_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !(cmd_wr && host_wdata[7:4] == `LDS_CMD_PAGE) |=> $stable(page_ff))
    else $error("page changed without command");
  a_read_pipe: assert property (@(posedge sys_clk) disable iff (rst)
    data_rd ##1 data_rd |=> rdata_ff == $past(mem_byte, 2))
    else $error("read pipeline wrong");
  a_frame_flip: assert property (@(posedge sys_clk) disable iff (rst)
    frame_end |=> frame_ff != $past(frame_ff) ##1 $stable(frame_ff))
    else $error("frame signal wrong");
  a_osc_stops: assert property (@(posedge sys_clk) disable iff (rst)
    !osc_on ##1 !osc_on |-> osc_cnt_ff == 8'h00 && !osc_running)
    else $error("oscillator runs");
  a_blank_off: assert property (@(posedge sys_clk) disable iff (rst)
    (disp_tick && !display_on) |=> segment_output == '0 && line_latch_stb)
    else $error("display off not blank");
  a_com_index: assert property (@(posedge sys_clk) disable iff (rst)
    disp_tick |=> common_index == $past(scan_idx_ff) ##0 line_latch_stb)
    else $error("common index wrong");
  a_icon_write: assert property (@(posedge sys_clk) disable iff (rst)
    (data_wr && page_ff == `LDS_ICON_PAGE && col_ff < `LDS_LAST_COL) |=>
    mem_ff[$past(col_ff)][`LDS_ICON_BIT] == $past(host_wdata[0]))
    else $error("icon bit not stored");
  a_stb_once: assert property (@(posedge sys_clk) disable iff (rst)
    line_latch_stb |=> !line_latch_stb)
    else $error("latch strobe too long");
  a_start_ld: assert property (@(posedge sys_clk) disable iff (rst)
    frame_end |=> start_act_ff == $past(start_ff))
    else $error("start line not applied");
  a_scan_end: assert property (@(posedge sys_clk) disable iff (rst)
    (disp_tick && scan_idx_ff == icon_pos) |=>
    scan_idx_ff == 7'h00 && common_index == $past(icon_pos))
    else $error("scan did not wrap");
endmodule

// ==== design/lds_defines.svh ====
// Constants for the display memory and scan timing block
`ifndef LDS_DEFINES_SVH
`define LDS_DEFINES_SVH
`define LDS_COLS 132
`define LDS_LAST_COL 8'h83
`define LDS_ICON_PAGE 4'h8
`define LDS_ICON_LINE 7'h40
`define LDS_ICON_BIT 7'h40
`define LDS_ICON_POS_65 7'h40
`define LDS_ICON_POS_49 7'h30
`define LDS_ICON_POS_33 7'h20
`define LDS_OSC_DIV 8'h7c
`define LDS_CMD_COL_LO 4'h0
`define LDS_CMD_COL_HI 4'h1
`define LDS_CMD_PAGE 4'hb
`define LDS_CMD_START 2'h1
`define LDS_RST_PAGE 4'h0
`define LDS_RST_COL 8'h00
`define LDS_RST_START 6'h00
`endif

// ==== design/lds_pkg.sv ====
// Types for the display memory and scan timing block
package lds_pkg;
  typedef logic [7:0] lds_byte_t;
  typedef enum logic [1:0] {
    LDS_DUTY_65,
    LDS_DUTY_49,
    LDS_DUTY_33,
    LDS_DUTY_RSVD
  } lds_duty_t;
endpackage

// ==== verification/lds_host_model.sv ====
// Host processor model driving command and data transfers
`timescale 1ns/1ps
module lds_host_model (
  input wire logic sys_clk,
  output logic host_wr_stb,
  output logic host_rd_stb,
  output logic data_command_select,
  output lds_pkg::lds_byte_t host_wdata
);
  initial begin
    host_wr_stb = 1'b0;
    host_rd_stb = 1'b0;
    data_command_select = 1'b0;
    host_wdata = 8'h00;
  end
  // One transfer held over one sampling edge
  task automatic xfer(input logic wr, input logic dc, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    host_wr_stb = wr;
    host_rd_stb = !wr;
    data_command_select = dc;
    host_wdata = wr ? d : ~host_wdata;
    @(posedge sys_clk);
    #1;
    host_wr_stb = 1'b0;
    host_rd_stb = 1'b0;
    host_wdata = ~host_wdata;
  endtask
  // Page command, then column high and low nibbles
  task automatic set_addr(input logic [3:0] pg, input logic [7:0] col);
    xfer(1'b1, 1'b0, {4'hb, pg});
    xfer(1'b1, 1'b0, {4'h1, col[7:4]});
    xfer(1'b1, 1'b0, {4'h0, col[3:0]});
  endtask
  // Back to back data reads, strobe held over cnt edges
  task automatic rd_burst(input int cnt);
    @(posedge sys_clk);
    #1;
    host_rd_stb = 1'b1;
    data_command_select = 1'b1;
    repeat (cnt) @(posedge sys_clk);
    #1;
    host_rd_stb = 1'b0;
  endtask
endmodule

// ==== verification/lcd_display_ram_scan_timing_tb.sv ====
// Self-checking bench for the display memory and scan timing block
`timescale 1ns/1ps
module lcd_display_ram_scan_timing_tb;
  logic sys_clk, rst, host_wr_stb, host_rd_stb, data_command_select;
  lds_pkg::lds_byte_t host_wdata, host_rdata;
  logic [3:0] current_page;
  logic [7:0] current_column;
  logic seg_reverse, display_inverse, display_on, all_points_on;
  lds_pkg::lds_duty_t duty_sel;
  logic master_slave_select, clock_source_select, display_clock_pin;
  logic osc_running, line_latch_stb, frame_polarity_signal, f;
  logic [131:0] segment_output;
  logic [6:0] common_index;
  int fails = 0, num_checks = 0, cycles = 0, n;
  lds_display_ram u_dut (.sys_clk, .rst, .host_wr_stb, .host_rd_stb,
    .data_command_select, .host_wdata, .host_rdata, .current_page,
    .current_column, .seg_reverse, .display_inverse, .display_on,
    .all_points_on, .duty_sel, .master_slave_select, .clock_source_select,
    .display_clock_pin, .osc_running, .segment_output, .common_index,
    .line_latch_stb, .frame_polarity_signal);
  lds_host_model u_host (.sys_clk, .host_wr_stb, .host_rd_stb,
    .data_command_select, .host_wdata);
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [131:0] got, input logic [131:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("Checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Wait for the next latched row of the given scan index
  task automatic wait_row(input logic [6:0] idx);
    n = 0;
    @(posedge sys_clk);
    #1;
    while (!(line_latch_stb === 1'b1 && common_index === idx) &&
           n < 9000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check(n < 9000, 1'b1);
  endtask
  task automatic t_host();
    u_host.set_addr(4'h2, 8'h53);
    u_host.xfer(1'b1, 1'b1, 8'haa);
    check(current_column, 8'h54);
    u_host.set_addr(4'h2, 8'h53);
    u_host.rd_burst(2);
    check(host_rdata, 8'haa);
    check(current_page, 4'h2);
    check(current_column, 8'h55);
    u_host.set_addr(4'h0, 8'h82);
    repeat (3) u_host.xfer(1'b1, 1'b1, 8'h00);
    u_host.xfer(1'b0, 1'b1, 8'h00);
    check(current_column, 8'h83);
    u_host.set_addr(4'h8, 8'h00);
    u_host.xfer(1'b1, 1'b1, 8'hff);
    u_host.set_addr(4'h8, 8'h00);
    repeat (2) u_host.xfer(1'b0, 1'b1, 8'h00);
    check(host_rdata, 8'h01);
    u_host.set_addr(4'h0, 8'h00);
    u_host.xfer(1'b1, 1'b1, 8'h01);
    u_host.xfer(1'b1, 1'b1, 8'h00);
  endtask
  task automatic t_scan();
    repeat (6) @(posedge sys_clk);
    #1;
    check(osc_running, 1'b1);
    wait_row(7'h00);
    check(segment_output[1:0], 2'h1);
    f = frame_polarity_signal;
    wait_row(7'h20);
    check(segment_output[0], 1'b1);
    wait_row(7'h00);
    check(frame_polarity_signal, !f);
    seg_reverse = 1'b1;
    wait_row(7'h00);
    check({segment_output[131], segment_output[0]}, 2'h2);
    display_inverse = 1'b1;
    wait_row(7'h00);
    check(segment_output[131], 1'b0);
    display_inverse = 1'b0;
    all_points_on = 1'b1;
    wait_row(7'h00);
    check(segment_output, {132{1'b1}});
    all_points_on = 1'b0;
    display_on = 1'b0;
    wait_row(7'h00);
    check(segment_output, 132'h0);
    display_on = 1'b1;
    u_host.xfer(1'b1, 1'b0, 8'h41);
    repeat (2) wait_row(7'h00);
    check(segment_output[131], 1'b0);
    u_host.xfer(1'b1, 1'b0, 8'h7f);
    repeat (2) wait_row(7'h00);
    wait_row(7'h01);
    check(segment_output[131], 1'b1);
    wait_row(7'h20);
    check(segment_output[131], 1'b1);
    duty_sel = lds_pkg::LDS_DUTY_49;
    wait_row(7'h30);
    check(segment_output[131], 1'b1);
  endtask
  task automatic t_ext();
    master_slave_select = 1'b0;
    repeat (10) @(posedge sys_clk);
    #1;
    check(osc_running, 1'b0);
    master_slave_select = 1'b1;
    clock_source_select = 1'b0;
    repeat (10) @(posedge sys_clk);
    #1;
    check(osc_running, 1'b0);
    n = 0;
    repeat (160) begin
      if (cycles % 40 == 10) display_clock_pin = 1'b1;
      if (cycles % 40 == 30) display_clock_pin = 1'b0;
      @(posedge sys_clk);
      #1;
      n += line_latch_stb;
    end
    repeat (40) begin
      @(posedge sys_clk);
      #1;
      n += line_latch_stb;
    end
    check(n, 4);
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 80000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    rst = 1'b1;
    seg_reverse = 1'b0;
    display_inverse = 1'b0;
    display_on = 1'b1;
    all_points_on = 1'b0;
    duty_sel = lds_pkg::LDS_DUTY_33;
    master_slave_select = 1'b1;
    clock_source_select = 1'b1;
    display_clock_pin = 1'b0;
    repeat (5) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    t_host();
    t_scan();
    t_ext();
    summarize();
  end
endmodule
